// ---- common/lpg_pkg.sv ----
package lpg_pkg;
  // ****************************************
  // clock and timing figures
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int PULSE_NS = 100;       // link pulse width
  localparam int NLP_PERIOD_MS = 16;   // normal pulse repeat
  localparam int CLK_PERIOD_US = 125;  // clock pulse to clock pulse
  localparam int DATA_OFS_US = 62;     // clock pulse to data pulse
  localparam int BURST_MS = 2;         // burst span
  localparam int FLP_PERIOD_MS = 16;   // burst to burst
  localparam int WORD_BITS = 16;       // code word length

  // cycle counts; pulse width rounded up to a whole cycle
  localparam int PULSE_CYC = (CLK_HZ / 1000 * PULSE_NS + 999_999)
                             / 1_000_000;
  localparam int US_CYC = CLK_HZ / 1_000_000;
  localparam int SLOT_CYC = CLK_PERIOD_US * US_CYC;
  localparam int DATA_CYC = DATA_OFS_US * US_CYC;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int NLP_CYC = NLP_PERIOD_MS * MS_CYC;
  localparam int FLP_CYC = FLP_PERIOD_MS * MS_CYC;
  localparam int BURST_CYC = BURST_MS * MS_CYC;

  // reset values
  localparam logic RST_PULSE = 1'b0;
endpackage

// ---- tb/lpg_link_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// link partner pulse receiver
// ****************************************
module lpg_link_partner #(
  parameter int SLOT = 20
) (
  input wire logic clk,        // clock
  input wire logic line,       // pulse on the wire
  output logic [15:0] word,    // decoded code word
  output logic [19:0] gap,     // rise to rise
  output logic [19:0] bgap,    // burst start to start
  output logic [3:0] width     // last pulse width
);
  logic [19:0] t = 20'h0, tc = 20'hfffff, bt = 20'h0;
  logic [4:0] idx = 5'h0;
  logic had = 1'b0, prev = 1'b0;
  // pulses classed by time since last clock pulse, as a receiver would
  always @(posedge clk) begin
    prev <= line;
    t <= t + 20'h1;
    tc <= tc + 20'h1;
    bt <= bt + 20'h1;
    width <= (line && !prev) ? 4'h1 : line ? width + 4'h1 : width;
    if (line && !prev) begin
      gap <= t;
      t <= 20'h1;
      if (tc < 20'(SLOT)) begin
        had <= 1'b1;
      end else begin
        tc <= 20'h1;
        had <= 1'b0;
        if (tc > 20'(SLOT)) begin
          idx <= 5'h0;
          bgap <= bt;
          bt <= 20'h1;
        end else begin
          if (idx < 5'h10) word[idx[3:0]] <= had;
          idx <= idx + 5'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/lpg_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pulse timing checker
// ****************************************
module lpg_mon #(
  parameter int FLP_PER = 400
) (
  input wire logic clk,          // clock
  input wire logic rst_n,        // reset, low
  input wire logic enable,       // generator on
  input wire logic aneg_en,      // burst mode
  input wire logic tx_pulse,     // line pulse
  input wire logic burst_active, // burst level
  input wire logic burst_done    // burst end
);
  logic [19:0] cnt_r;
  logic seen_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // burst start spacing; forgotten whenever mode drops, so a
  // restart is never held to the old period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 20'h0;
      seen_r <= 1'b0;
    end else begin
      cnt_r <= $rose(burst_active) ? 20'h1 : cnt_r + 20'h1;
      seen_r <= enable && aneg_en && (seen_r || $rose(burst_active));
    end
  end
  pulse_width_a: assert property (
    $rose(tx_pulse) |-> tx_pulse[*3] ##1 !tx_pulse)
    else $error("pulse width wrong");
  pulse_gap_a: assert property (
    $rose(tx_pulse) |=> (!$rose(tx_pulse))[*8])
    else $error("pulses too close");
  done_single_a: assert property (
    burst_done |=> !burst_done)
    else $error("burst end longer than one cycle");
  done_in_burst_a: assert property (
    burst_done |-> $past(burst_active))
    else $error("burst end without burst");
  burst_period_a: assert property (
    $rose(burst_active) && seen_r |-> cnt_r == 20'(FLP_PER))
    else $error("burst period wrong");
  burst_mode_a: assert property (
    $rose(burst_active) |-> aneg_en || $past(aneg_en))
    else $error("burst in normal pulse mode");
endmodule
`default_nettype wire

// ---- tb/test_lpg_link_pulse_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// link pulse generator bench
// ****************************************
module test_lpg_link_pulse_gen;
  import lpg_pkg::*;
  localparam int NLP = 50, FLP = 400, SL = 20, DO = 10;
  logic clk = 0, rst_n = 0, enable = 0, aneg_en = 0;
  logic [WORD_BITS-1:0] code_word = '0, cw;
  logic tx_pulse, burst_active, burst_done;
  logic [15:0] word;
  logic [19:0] gap, bgap;
  logic [3:0] width;
  int bad_count = 0, checks_done = 0;
  logic [15:0] corner [4] = '{16'h0000, 16'hffff, 16'h0001, 16'h8000};
  lpg_link_pulse_gen #(.NLP_PER(NLP), .FLP_PER(FLP), .SLOT(SL),
    .DOFS(DO)) u_lpg_link_pulse_gen (.clk(clk), .rst_n(rst_n),
    .enable(enable), .aneg_en(aneg_en), .code_word(code_word),
    .tx_pulse(tx_pulse), .burst_active(burst_active),
    .burst_done(burst_done));
  lpg_link_partner #(.SLOT(SL)) u_lpg_link_partner (.clk(clk),
    .line(tx_pulse), .word(word), .gap(gap), .bgap(bgap), .width(width));
  initial forever #20 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // 100 ns rounded up to whole clock cycles
  function automatic int exp_width();
    return (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  endfunction
  // last gap of a burst hangs on the top bit
  function automatic int exp_gap(input logic [15:0] w);
    return w[15] ? SL - DO : SL;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h8fb0));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) enable <= 1'b1;
    repeat (3 * NLP + 10) @(negedge clk);
    check(gap, NLP);
    check(width, exp_width());
    cw = corner[0];
    @(posedge clk) begin
      aneg_en <= 1'b1;
      code_word <= cw;
    end
    for (int i = 0; i < 8; i++) begin
      // bounded wait for the end of the burst
      for (int n = 0; burst_done !== 1'b1; n++) begin
        @(negedge clk);
        if (n > 2 * FLP) begin
          // a burst that never ends is a failure, not a quiet exit
          bad_count++;
          summarize();
        end
      end
      check(word, cw);
      check(width, exp_width());
      check(gap, exp_gap(cw));
      if (i > 0) check(bgap, FLP);
      cw = i < 3 ? corner[i + 1] : 16'($urandom);
      @(posedge clk) code_word <= cw;
      // step off the edge so the old done pulse is seen as gone
      @(negedge clk);
    end
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
bind lpg_link_pulse_gen lpg_mon #(.FLP_PER(FLP_PER)) u_lpg_mon (.clk(clk),
  .rst_n(rst_n), .enable(enable), .aneg_en(aneg_en), .tx_pulse(tx_pulse),
  .burst_active(burst_active), .burst_done(burst_done));
`default_nettype wire

// ---- verilog/lpg_link_pulse_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// link pulse generator
// ****************************************
// Contract
// - idle 10M: 100 ns pulse every 16 ms; code gives 3 cycles, 120 ns
// - burst clock/data pulses last 100 ns; code gives 3 cycles, 120 ns
// - clock pulses 125 us apart, one slot
// - bit one: data pulse 62 us later
// - burst spans 2 ms, repeats 16 ms
module lpg_link_pulse_gen
  import lpg_pkg::*;
#(
  parameter int NLP_PER = NLP_CYC,   // normal pulse period, cycles
  parameter int FLP_PER = FLP_CYC,   // burst period, cycles
  parameter int SLOT = SLOT_CYC,     // clock-to-clock, cycles
  parameter int DOFS = DATA_CYC,     // clock-to-data, cycles
  parameter int NBITS = WORD_BITS    // code word bits
) (
  input wire logic clk,                   // 25 MHz clock
  input wire logic rst_n,                 // async reset, low
  input wire logic enable,                // generator on
  input wire logic aneg_en,               // bursts instead of pulses
  input wire logic [NBITS-1:0] code_word, // word to advertise
  output logic tx_pulse,                  // pulse to line driver
  output logic burst_active,              // burst in progress
  output logic burst_done                 // one-cycle, burst ended
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_NLP = 3'b010,
    S_FLP = 3'b100
  } lpg_state_t;

  typedef struct packed {
    lpg_state_t state;
    logic [31:0] per_cnt;   // period counter
    logic [31:0] slot_cnt;  // position inside slot
    logic [5:0] bit_idx;    // index of current slot
    logic [NBITS-1:0] word; // latched word
    logic fire;
    logic active;
    logic done;
  } lpg_st_t;

  lpg_st_t st_r, st_nxt;
  logic pulse_w;

  initial begin
    if (NBITS < 1 || NBITS > 31) $error("lpg: bad NBITS");
    if (DOFS < 1 || DOFS >= SLOT) $error("lpg: data must sit in slot");
    if (SLOT * (NBITS + 1) > FLP_PER) $error("lpg: burst longer than period");
  end

  // ****************************************
  // sequencing
  // ****************************************
  // one free-running period counter; bursts and pulses start at zero
  always_comb begin
    st_nxt = st_r;
    st_nxt.fire = 1'b0;
    st_nxt.done = 1'b0;
    unique case (st_r.state)
      S_IDLE: begin
        st_nxt.per_cnt = '0;
        st_nxt.active = 1'b0;
        if (enable) begin
          st_nxt.state = aneg_en ? S_FLP : S_NLP;
        end
      end
      S_NLP: begin
        // single pulse at the start of each 16 ms period
        st_nxt.fire = (st_r.per_cnt == '0);
        if (st_r.per_cnt == 32'(NLP_PER - 1)) begin
          st_nxt.per_cnt = '0;
          if (!enable || aneg_en) begin
            st_nxt.state = S_IDLE;
          end
        end else begin
          st_nxt.per_cnt = st_r.per_cnt + 32'h1;
        end
      end
      S_FLP: begin
        if (st_r.per_cnt == '0) begin
          // latch word so a change mid-burst cannot tear it
          st_nxt.word = code_word;
          st_nxt.bit_idx = '0;
          st_nxt.slot_cnt = '0;
          st_nxt.active = 1'b1;
        end else if (st_r.active) begin
          if (st_r.slot_cnt == 32'(SLOT - 1)) begin
            st_nxt.slot_cnt = '0;
            st_nxt.bit_idx = st_r.bit_idx + 6'h1;
            st_nxt.word = st_r.word >> 1;
          end else begin
            st_nxt.slot_cnt = st_r.slot_cnt + 32'h1;
          end
        end
        if (st_r.active || st_r.per_cnt == '0) begin
          // clock pulse at slot start, NBITS+1 of them per burst
          if (st_nxt.slot_cnt == '0 &&
              st_nxt.bit_idx <= 6'(NBITS)) begin
            st_nxt.fire = 1'b1;
          end
          // data pulse only for a one bit, LSB first
          if (st_r.slot_cnt == 32'(DOFS - 1) && st_r.word[0] &&
              st_r.bit_idx < 6'(NBITS)) begin
            st_nxt.fire = 1'b1;
          end
          if (st_r.bit_idx == 6'(NBITS) &&
              st_r.slot_cnt == 32'(DOFS - 1)) begin
            st_nxt.active = 1'b0;
            st_nxt.done = 1'b1;
          end
        end
        if (st_r.per_cnt == 32'(FLP_PER - 1)) begin
          st_nxt.per_cnt = '0;
          if (!enable || !aneg_en) begin
            st_nxt.state = S_IDLE;
          end
        end else begin
          st_nxt.per_cnt = st_r.per_cnt + 32'h1;
        end
      end
      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: S_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // pulse shaping
  // ****************************************
  lpg_pulse_stretch #(
    .WIDTH(PULSE_CYC)
  ) u_stretch (
    .clk(clk),
    .rst_n(rst_n),
    .fire(st_r.fire),
    .pulse_o(pulse_w)
  );

  assign tx_pulse = pulse_w;
  assign burst_active = st_r.active;
  assign burst_done = st_r.done;
endmodule
`default_nettype wire

// ---- verilog/lpg_pulse_stretch.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// fixed-width pulse former
// ****************************************
module lpg_pulse_stretch
  import lpg_pkg::*;
#(
  parameter int WIDTH = PULSE_CYC
) (
  input wire logic clk,   // system clock
  input wire logic rst_n, // async reset, low
  input wire logic fire,  // one-cycle start
  output logic pulse_o    // registered pulse
);
  typedef struct packed {
    logic [7:0] cnt;
    logic pulse;
  } lpg_ps_t;

  lpg_ps_t st_r, st_nxt;

  initial begin
    if (WIDTH < 1 || WIDTH > 255) $error("lpg_pulse_stretch: bad WIDTH");
  end

  // a new fire restarts the width, so a fire during a pulse stretches it into one longer pulse
  always_comb begin
    st_nxt = st_r;
    if (fire) begin
      st_nxt.cnt = 8'(WIDTH - 1);
      st_nxt.pulse = 1'b1;
    end else if (st_r.cnt != 8'h00) begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end else begin
      st_nxt.pulse = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pulse_o = st_r.pulse;
endmodule
`default_nettype wire
